//--- gir_pkg.sv
// Package holding the register map, field layout and reset values of the pin-level block.
package gir_pkg;

  // Pin organisation: banks of sixteen pins, banks paired into one 32-bit word.
  localparam int unsigned PIN_COUNT     = 104;
  localparam int unsigned BANK_WIDTH    = 16;
  localparam int unsigned WORD_COUNT    = 4;
  localparam int unsigned LAST_WORD_PINS = 8;

  // Field positions inside each paired word.
  localparam int unsigned EVEN_BANK_LSB = 0;
  localparam int unsigned ODD_BANK_LSB  = 16;

  // Bus widths.
  localparam int unsigned ADDR_WIDTH    = 5;
  localparam int unsigned DATA_WIDTH    = 32;
  localparam int unsigned BE_WIDTH      = 4;

  // Byte offsets of the registers.
  localparam logic [ADDR_WIDTH-1:0] BANK01_PIN_LEVELS_OFS      = 5'h00;
  localparam logic [ADDR_WIDTH-1:0] BANK23_PIN_LEVELS_OFS      = 5'h04;
  localparam logic [ADDR_WIDTH-1:0] BANK45_PIN_LEVELS_OFS      = 5'h08;
  localparam logic [ADDR_WIDTH-1:0] BANK6_PIN_LEVELS_OFS       = 5'h0C;
  localparam logic [ADDR_WIDTH-1:0] BANK01_RISE_ENABLE_SET_OFS = 5'h10;
  localparam logic [ADDR_WIDTH-1:0] BANK23_RISE_ENABLE_SET_OFS = 5'h14;
  localparam logic [ADDR_WIDTH-1:0] BANK45_RISE_ENABLE_SET_OFS = 5'h18;
  localparam logic [ADDR_WIDTH-1:0] BANK6_RISE_ENABLE_SET_OFS  = 5'h1C;

  // Reset values.
  localparam logic [DATA_WIDTH-1:0] RISE_ENABLE_RESET = 32'h00000000;
  localparam logic [DATA_WIDTH-1:0] READ_DATA_RESET   = 32'h00000000;
  localparam logic [DATA_WIDTH-1:0] UNMAPPED_READ     = 32'h00000000;
  localparam logic                  SYNC_RESET        = 1'h0;

  // Bus answer states.
  typedef enum logic {GIR_IDLE, GIR_ANSWER} gir_bus_state_t;

endpackage : gir_pkg

//--- gir_pin_sync.sv
// Three-stage pin synchroniser whose output follows only once stages two and three agree.
`timescale 1ns/10ps
`default_nettype none
module gir_pin_sync
  import gir_pkg::*;
#(
  parameter int unsigned WIDTH = 16
)
(
  // Clock and reset.
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Pins and synchronised levels.
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinLevel
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] level_reg;
  logic [WIDTH-1:0] level_next;

  // A bit moves only when the two settled stages agree, which rejects a one-cycle glitch.
  always_comb
  begin
    level_next = level_reg;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (stage2_reg[i] == stage3_reg[i])
      begin
        level_next[i] = stage3_reg[i];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      stage1_reg <= {WIDTH{SYNC_RESET}};
      stage2_reg <= {WIDTH{SYNC_RESET}};
      stage3_reg <= {WIDTH{SYNC_RESET}};
      level_reg  <= {WIDTH{SYNC_RESET}};
    end
    else
    begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      level_reg  <= level_next;
    end
  end

  assign pinLevel = level_reg;

endmodule : gir_pin_sync
`default_nettype wire

//--- gir_rise_enable.sv
// One word of write-one-to-set rising-edge enables; the set mask arrives already gated by byte lane.
`timescale 1ns/10ps
`default_nettype none
module gir_rise_enable
  import gir_pkg::*;
#(
  parameter int unsigned WIDTH = 32
)
(
  // Clock and reset.
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // Set request from the bus.
  input  wire logic                  setStrobe,
  input  wire logic [WIDTH-1:0]      setMask,
  // Enable state.
  output logic      [WIDTH-1:0]      riseEnable
);

  logic [WIDTH-1:0] enable_reg;
  logic [WIDTH-1:0] enable_next;

  // Ones in the mask arm pins; zeros leave them as they were.
  always_comb
  begin
    enable_next = enable_reg;
    if (setStrobe)
    begin
      enable_next = enable_reg | setMask;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      enable_reg <= RISE_ENABLE_RESET[WIDTH-1:0];
    end
    else
    begin
      enable_reg <= enable_next;
    end
  end

  assign riseEnable = enable_reg;

endmodule : gir_rise_enable
`default_nettype wire

//--- gir_pin_levels.sv
// Top of the pin-level readback and rising-edge enable block, with its Avalon-MM slave.
//
// Contract
// - Bits 31-16 of each level word show the odd bank's pins.
// - Bits 15-0 of each level word show the even bank's pins.
// - A level bit reads 1 for a high pin and 0 for low.
// - Per-pin set registers let software enable rising-edge interrupts.
// - Writing 1 arms a pin's rising enable; writing 0 changes nothing.
// - Bits 31-16 of each rise-set word configure the odd bank.
// - Bits 15-0 of each rise-set word configure the even bank.
// - Reading a rise-set bit returns the pin's enable state, not last write.
// - An input pin's level bit shows the synchronised pin level.
// - An output pin's level bit shows the value being driven.
`timescale 1ns/10ps
`default_nettype none
module gir_pin_levels
  import gir_pkg::*;
(
  // Clock and reset.
  input  wire logic                            sys_clk,
  input  wire logic                            rst,
  // Avalon-MM slave.
  input  wire logic [gir_pkg::ADDR_WIDTH-1:0]  avs_address,
  input  wire logic                            avs_read,
  input  wire logic                            avs_write,
  input  wire logic [gir_pkg::DATA_WIDTH-1:0]  avs_writedata,
  input  wire logic [gir_pkg::BE_WIDTH-1:0]    avs_byteenable,
  output logic      [gir_pkg::DATA_WIDTH-1:0]  avs_readdata,
  output logic                                 avs_waitrequest,
  // Pins and the direction and output logic beside this block.
  input  wire logic [gir_pkg::PIN_COUNT-1:0]   pinIn,
  input  wire logic [gir_pkg::PIN_COUNT-1:0]   pinDirection,
  input  wire logic [gir_pkg::PIN_COUNT-1:0]   pinDriveValue,
  // Rising-edge enables for the edge detector.
  output logic      [gir_pkg::PIN_COUNT-1:0]   riseEnable
);

  // Two banks to a word, so the padded vector spans every word in full.
  localparam int unsigned PADDED_PINS = WORD_COUNT * DATA_WIDTH;

  logic [PIN_COUNT-1:0]         syncLevel;
  logic [PIN_COUNT-1:0]         pinLevel;
  logic [PADDED_PINS-1:0]       levelPadded;
  logic [PADDED_PINS-1:0]       enablePadded;
  logic [DATA_WIDTH-1:0]        levelWord  [WORD_COUNT];
  logic [DATA_WIDTH-1:0]        enableWord [WORD_COUNT];
  logic [DATA_WIDTH-1:0]        laneMask;
  logic [WORD_COUNT-1:0]        setStrobe;
  logic [DATA_WIDTH-1:0]        readValue;
  logic                         readHit;
  gir_bus_state_t               state_reg;
  gir_bus_state_t               state_next;
  logic [DATA_WIDTH-1:0]        readdata_reg;
  logic [DATA_WIDTH-1:0]        readdata_next;

  // Every pin is synchronised, even when driven, so a direction flip reads cleanly.
  gir_pin_sync #(
    .WIDTH    (PIN_COUNT)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .pinIn    (pinIn),
    .pinLevel (syncLevel)
  );

  // Direction bit 1 is an input; outputs read back their drive value.
  always_comb
  begin
    for (int i = 0; i < PIN_COUNT; i++)
    begin
      if (pinDirection[i])
      begin
        pinLevel[i] = syncLevel[i];
      end
      else
      begin
        pinLevel[i] = pinDriveValue[i];
      end
    end
  end

  // Pins beyond the last bank read as zero in the upper part of the last word.
  assign levelPadded  = {{(PADDED_PINS-PIN_COUNT){1'b0}}, pinLevel};
  assign enablePadded = {{(PADDED_PINS-PIN_COUNT){1'b0}}, riseEnable};

  // Each word holds the even bank low and the odd bank high.
  genvar w;
  generate
    for (w = 0; w < WORD_COUNT; w++)
    begin : g_word
      assign levelWord[w][EVEN_BANK_LSB +: BANK_WIDTH] =
        levelPadded[(2*w)*BANK_WIDTH +: BANK_WIDTH];
      assign levelWord[w][ODD_BANK_LSB +: BANK_WIDTH] =
        levelPadded[(2*w+1)*BANK_WIDTH +: BANK_WIDTH];
      assign enableWord[w][EVEN_BANK_LSB +: BANK_WIDTH] =
        enablePadded[(2*w)*BANK_WIDTH +: BANK_WIDTH];
      assign enableWord[w][ODD_BANK_LSB +: BANK_WIDTH] =
        enablePadded[(2*w+1)*BANK_WIDTH +: BANK_WIDTH];
    end
  endgenerate

  // Byte enables gate which lanes of a set write may arm pins.
  always_comb
  begin
    for (int b = 0; b < BE_WIDTH; b++)
    begin
      laneMask[b*8 +: 8] = avs_writedata[b*8 +: 8] & {8{avs_byteenable[b]}};
    end
  end

  // A write takes effect only at the edge where waitrequest is low.
  always_comb
  begin
    setStrobe = '0;
    if ((state_reg == GIR_ANSWER) && avs_write)
    begin
      if (avs_address == BANK01_RISE_ENABLE_SET_OFS)
      begin
        setStrobe[0] = 1'b1;
      end
      else if (avs_address == BANK23_RISE_ENABLE_SET_OFS)
      begin
        setStrobe[1] = 1'b1;
      end
      else if (avs_address == BANK45_RISE_ENABLE_SET_OFS)
      begin
        setStrobe[2] = 1'b1;
      end
      else if (avs_address == BANK6_RISE_ENABLE_SET_OFS)
      begin
        setStrobe[3] = 1'b1;
      end
    end
  end

  // Three full words of enables; the last word only covers its real pins.
  gir_rise_enable #(
    .WIDTH      (DATA_WIDTH)
  ) u_en01 (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .setStrobe  (setStrobe[0]),
    .setMask    (laneMask),
    .riseEnable (riseEnable[0 +: DATA_WIDTH])
  );

  gir_rise_enable #(
    .WIDTH      (DATA_WIDTH)
  ) u_en23 (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .setStrobe  (setStrobe[1]),
    .setMask    (laneMask),
    .riseEnable (riseEnable[DATA_WIDTH +: DATA_WIDTH])
  );

  gir_rise_enable #(
    .WIDTH      (DATA_WIDTH)
  ) u_en45 (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .setStrobe  (setStrobe[2]),
    .setMask    (laneMask),
    .riseEnable (riseEnable[2*DATA_WIDTH +: DATA_WIDTH])
  );

  gir_rise_enable #(
    .WIDTH      (LAST_WORD_PINS)
  ) u_en6 (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .setStrobe  (setStrobe[3]),
    .setMask    (laneMask[LAST_WORD_PINS-1:0]),
    .riseEnable (riseEnable[3*DATA_WIDTH +: LAST_WORD_PINS])
  );

  // Read decode; unmapped offsets answer with zero.
  always_comb
  begin
    readHit   = 1'b1;
    readValue = UNMAPPED_READ;
    if (avs_address == BANK01_PIN_LEVELS_OFS)
    begin
      readValue = levelWord[0];
    end
    else if (avs_address == BANK23_PIN_LEVELS_OFS)
    begin
      readValue = levelWord[1];
    end
    else if (avs_address == BANK45_PIN_LEVELS_OFS)
    begin
      readValue = levelWord[2];
    end
    else if (avs_address == BANK6_PIN_LEVELS_OFS)
    begin
      readValue = levelWord[3];
    end
    else if (avs_address == BANK01_RISE_ENABLE_SET_OFS)
    begin
      readValue = enableWord[0];
    end
    else if (avs_address == BANK23_RISE_ENABLE_SET_OFS)
    begin
      readValue = enableWord[1];
    end
    else if (avs_address == BANK45_RISE_ENABLE_SET_OFS)
    begin
      readValue = enableWord[2];
    end
    else if (avs_address == BANK6_RISE_ENABLE_SET_OFS)
    begin
      readValue = enableWord[3];
    end
    else
    begin
      readHit = 1'b0;
    end
  end

  // Every access takes one wait cycle, which lets read data come from a register.
  always_comb
  begin
    state_next    = state_reg;
    readdata_next = readdata_reg;
    case (state_reg)
      GIR_IDLE:
      begin
        if (avs_read || avs_write)
        begin
          state_next = GIR_ANSWER;
        end
        if (avs_read)
        begin
          readdata_next = readHit ? readValue : UNMAPPED_READ;
        end
      end
      GIR_ANSWER:
      begin
        state_next = GIR_IDLE;
      end
      default:
      begin
        state_next = GIR_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg    <= GIR_IDLE;
      readdata_reg <= READ_DATA_RESET;
    end
    else
    begin
      state_reg    <= state_next;
      readdata_reg <= readdata_next;
    end
  end

  assign avs_waitrequest = (state_reg != GIR_ANSWER);
  assign avs_readdata    = readdata_reg;

endmodule : gir_pin_levels
`default_nettype wire

//--- gir_pin_levels_checker.sv
// Assertions on the bus handshake, rising enables and level readback of the pin-level block.
`timescale 1ns/10ps
`default_nettype none
module gir_pin_levels_checker
  import gir_pkg::*;
(
  // Clock and reset.
  input wire logic         sys_clk,
  input wire logic         rst,
  // Bus.
  input wire logic [4:0]   avs_address,
  input wire logic         avs_read,
  input wire logic         avs_write,
  input wire logic [31:0]  avs_writedata,
  input wire logic [3:0]   avs_byteenable,
  input wire logic [31:0]  avs_readdata,
  input wire logic         avs_waitrequest,
  // Pins and enables.
  input wire logic [103:0] pinIn,
  input wire logic [103:0] pinDirection,
  input wire logic [103:0] pinDriveValue,
  input wire logic [103:0] riseEnable
);
  logic        take;
  logic        ack;
  logic        wrAck;
  logic [31:0] laneMask;
  always_comb
  begin
    take = (avs_read || avs_write) && avs_waitrequest;
    ack = !avs_waitrequest;
    wrAck = ack && avs_write;
    laneMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_take_answer: assert property (take |=> ack)
    else $error("request not answered one cycle after it was taken");
  a_idle_quiet: assert property (!take |=> avs_waitrequest)
    else $error("answer without a pending request");
  a_set_or: assert property (wrAck && avs_address == 5'h10 |=> riseEnable[31:0] ==
    ($past(riseEnable[31:0]) | ($past(avs_writedata) & $past(laneMask))))
    else $error("set word did not OR the enabled lanes in");
  a_set_sticky: assert property ((riseEnable & $past(riseEnable)) == $past(riseEnable))
    else $error("a rising enable was cleared");
  a_set_cause: assert property ($changed(riseEnable) |-> $past(wrAck))
    else $error("rising enables changed without a write");
  a_read_enable: assert property (ack && avs_read && avs_address == 5'h14 |->
    avs_readdata == riseEnable[63:32]) else $error("set word read is not the enable state");
  a_drive_readback: assert property (ack && avs_read && avs_address == 5'h04 &&
    $past(pinDirection[63:32]) == 32'h0 |-> avs_readdata == $past(pinDriveValue[63:32]))
    else $error("output pins do not read back the driven value");
  a_word3_upper: assert property (ack && avs_read && avs_address == 5'h0C |->
    avs_readdata[31:8] == 24'h0) else $error("unused level bits not zero");
  a_reset_clear: assert property (disable iff (1'b0) rst |->
    riseEnable == 104'h0 && avs_waitrequest) else $error("reset did not clear enables");
  c_write: cover property (wrAck);
  c_read: cover property (ack && avs_read);
  c_arm: cover property ($changed(riseEnable));
endmodule : gir_pin_levels_checker
bind gir_pin_levels gir_pin_levels_checker u_checker (.sys_clk(sys_clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pinIn(pinIn),
  .pinDirection(pinDirection), .pinDriveValue(pinDriveValue), .riseEnable(riseEnable));
`default_nettype wire

//--- gir_pin_model.sv
// Board pins: levels follow the command at once or one cycle late.
`timescale 1ns/10ps
`default_nettype none
module gir_pin_model
(
  // Clock.
  input wire logic          sys_clk,
  // Commanded levels and pace.
  input wire logic [103:0]  levelCmd,
  input wire logic          slow,
  // Pins toward the block.
  output logic     [103:0]  pinIn
);
  logic [103:0] lagReg;
  always_ff @(posedge sys_clk)
  begin
    lagReg <= levelCmd;
  end
  assign pinIn = slow ? lagReg : levelCmd;
endmodule : gir_pin_model
`default_nettype wire

//--- gir_pin_levels_bench.sv
// Self-checking bench for the pin-level block.
`timescale 1ns/10ps
`default_nettype none
module gir_pin_levels_bench;
  import gir_pkg::*;
  localparam logic [103:0] patLevels = 104'hA5_1234_5678_9ABC_DEF0_0FED_CBA9;
  logic sys_clk, rst, avs_read, avs_write, avs_waitrequest, slowPins;
  logic [4:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rdData, setData;
  logic [103:0] pinLevelCmd, pinIn, pinDirection, pinDriveValue, riseEnable;
  logic [127:0] expWords;
  int errors, compares;

  gir_pin_levels DUT (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pinIn(pinIn), .pinDirection(pinDirection),
    .pinDriveValue(pinDriveValue), .riseEnable(riseEnable));
  gir_pin_model pins (.sys_clk(sys_clk), .levelCmd(pinLevelCmd), .slow(slowPins),
    .pinIn(pinIn));

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic print_verdict;
    $display("Counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  // Called just after a rising edge; waitrequest is looked at mid-cycle so the
  // edge that takes the answer is the one where it stands low.
  task automatic bus_access(input logic wr, input logic [4:0] a, input logic [31:0] d,
                            input logic [3:0] be);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    do
    begin
      @(negedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    @(posedge sys_clk);
    rdData = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
    if (n >= 20)
    begin
      errors++;
      $display("FAIL bus answer expected waitrequest low seen none");
      print_verdict();
    end
  endtask : bus_access

  task automatic check_words(input string what, input logic [4:0] base,
                             input logic [127:0] exp);
    for (int n = 0; n < 4; n++)
    begin
      bus_access(1'b0, base + 5'(4 * n), 32'h0, 4'hF);
      check_word(what, exp[32*n+:32], rdData);
    end
  endtask : check_words

  initial
  begin
    // Raised in the update region so the asynchronous reset branches see the edge at time zero.
    rst <= 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    pinLevelCmd = 104'h0;
    slowPins = 1'b0;
    pinDirection = {104{1'b1}};
    pinDriveValue = 104'h0;
    errors = 0;
    compares = 0;
    expWords = 128'h0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    check_words("reset enable", 5'h10, 128'h0);
    $display("Test reset done");
    for (int n = 0; n < 4; n++)
    begin
      setData = 32'h8001_0003 << n;
      bus_access(1'b1, 5'h10 + 5'(4 * n), setData, 4'hF);
      bus_access(1'b1, 5'h10 + 5'(4 * n), 32'h0, 4'hF);
      expWords[32*n+:32] = (n == 3) ? (setData & 32'hFF) : setData;
    end
    bus_access(1'b1, 5'h10, 32'hFFFF_FFFF, 4'h4);
    expWords[23:16] = 8'hFF;
    check_words("set word", 5'h10, expWords);
    check_word("enable port", expWords[63:32], riseEnable[63:32]);
    $display("Test set done");
    pinLevelCmd <= patLevels;
    slowPins <= 1'b1;
    bus_access(1'b0, 5'h00, 32'h0, 4'hF);
    check_word("level before sync", 32'h0, rdData);
    repeat (6) @(posedge sys_clk);
    bus_access(1'b1, 5'h00, 32'hFFFF_FFFF, 4'hF);
    check_words("level word", 5'h00, {24'h0, patLevels});
    pinLevelCmd <= ~patLevels;
    slowPins <= 1'b0;
    repeat (6) @(posedge sys_clk);
    check_words("inverted level", 5'h00, {24'h0, ~patLevels});
    $display("Test input levels done");
    pinDirection <= 104'h0;
    pinDriveValue <= {patLevels[51:0], patLevels[103:52]};
    @(posedge sys_clk);
    check_words("driven level", 5'h00, {24'h0, patLevels[51:0], patLevels[103:52]});
    $display("Test output levels done");
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    check_words("second reset", 5'h10, 128'h0);
    $display("Test second reset done");
    print_verdict();
  end
endmodule : gir_pin_levels_bench
`default_nettype wire
